// >>> logic/nfc_cfg.svh
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
`define NFC_REG_CTRL 12'h000
`define NFC_REG_CMD 12'h004
`define NFC_REG_ADDR 12'h008
`define NFC_REG_WDATA 12'h00C
`define NFC_REG_RDATA 12'h010
`define NFC_REG_STATUS 12'h014
`define NFC_CTRL_CE_BIT 0
`define NFC_CTRL_WP_BIT 1
`define NFC_CTRL_SE_BIT 2
`define NFC_CTRL_RESET 3'h2
`define NFC_CMD_READ0 8'h00
`define NFC_CMD_READ1 8'h01
`define NFC_CMD_GAPLESS 8'h02
`define NFC_CMD_SPARE 8'h50
`define NFC_CMD_ID 8'h90
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_INPUT 8'h80
`define NFC_CMD_PROGRAM 8'h10
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hD0
`define NFC_CMD_SUSPEND 8'hB0
`define NFC_CMD_RESET 8'hFF
`define NFC_CLK_MHZ 125
`define NFC_STROBE_NS 40
`define NFC_STROBE_CYC ((`NFC_STROBE_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_STROBE_LOAD 4'(`NFC_STROBE_CYC - 1)
`define NFC_BUSY_LIMIT 16'h61A8
`endif

// >>> logic/nfc_pkg.sv
package nfc_pkg;
    typedef struct packed {
        logic cmdLatch;
        logic addrLatch;
        logic chipSel_n;
        logic writeStrobe_n;
        logic read_strobe_n;
        logic writeProt_n;
        logic spare_access_n;
    } nfc_pins_type;
    typedef enum logic [1:0] {
        OP_CMD,
        OP_ADDR,
        OP_WDATA,
        OP_RDATA
    } nfc_op_type;
endpackage : nfc_pkg

// >>> logic/nfc_host.sv
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output nfc_pkg::nfc_pins_type pins,
    output logic [7:0] ioOut,
    output logic ioOe,
    input wire logic [7:0] ioIn,
    input wire logic ready_busy_n
);
    import nfc_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0] ioMeta_ff, ioSync_ff;
    logic rbMeta_ff, rbSync_ff;
    // Data bus synchroniser
    always_ff @(posedge clk) begin
        ioMeta_ff <= ioIn;
        ioSync_ff <= ioMeta_ff;
    end

    // Ready line synchroniser
    always_ff @(posedge clk) begin
        rbMeta_ff <= ready_busy_n;
        rbSync_ff <= rbMeta_ff;
    end

    // ****************************************
    // Bus decode
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_LOW,
        ST_HIGH,
        ST_DONE
    } nfc_state_type;

    nfc_state_type state_ff, nxt_state;
    nfc_op_type op_ff;
    logic [2:0] ctrl_ff;
    logic [7:0] rdata_ff;
    logic [3:0] cnt_ff;
    logic busyOp_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    nfc_pins_type pins_ff;
    logic [7:0] ioOut_ff;
    logic ioOe_ff;
    logic [1:0] lastOp_ff;
    logic [2:0] addrCnt_ff;
    logic [15:0] busyCnt_ff;
    logic overrun_ff;

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
        reg_hit = addr == offset;
    endfunction : reg_hit

    wire access = psel && penable && !pready_ff;
    wire wrAcc = access && pwrite;
    wire rdAcc = access && !pwrite;
    wire hitCtrl = reg_hit(paddr, `NFC_REG_CTRL);
    wire hitCmd = reg_hit(paddr, `NFC_REG_CMD);
    wire hitAddr = reg_hit(paddr, `NFC_REG_ADDR);
    wire hitWdata = reg_hit(paddr, `NFC_REG_WDATA);
    wire hitRdata = reg_hit(paddr, `NFC_REG_RDATA);
    wire hitStatus = reg_hit(paddr, `NFC_REG_STATUS);
    wire hitAny = hitCtrl | hitCmd | hitAddr | hitWdata | hitRdata | hitStatus;
    // Flash cycles occupy the bus until the strobe pair completes
    wire pinReq = (wrAcc && (hitCmd || hitAddr || hitWdata)) || (rdAcc && hitRdata);
    wire immAck = access && !pinReq && state_ff == ST_IDLE;
    wire pinAck = access && state_ff == ST_DONE;
    wire [31:0] statusWord = {23'h0, overrun_ff, addrCnt_ff, lastOp_ff, busyOp_ff, !rbSync_ff, rbSync_ff};
    wire [31:0] immRead = hitCtrl ? {29'h0, ctrl_ff} : hitStatus ? statusWord : 32'h0;
    wire cntZero = cnt_ff == 4'h0;
    wire startOp = pinReq && state_ff == ST_IDLE;
    wire [1:0] reqOp = hitCmd ? OP_CMD : hitAddr ? OP_ADDR : pwrite ? OP_WDATA : OP_RDATA;

    // ****************************************
    // Strobe sequencer
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (startOp) begin
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cntZero) begin
                    nxt_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (cntZero) begin
                    nxt_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (cntZero) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Each phase lasts the strobe count from the cycle it is entered
    wire [3:0] nxt_cnt = (nxt_state != state_ff) ? `NFC_STROBE_LOAD : (cntZero ? 4'h0 : cnt_ff - 4'h1);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_ff <= OP_CMD;
        end else if (startOp) begin
            op_ff <= nfc_op_type'(reqOp);
        end
    end

    // ****************************************
    // Control register and pins
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= `NFC_CTRL_RESET;
        end else if (wrAcc && hitCtrl) begin
            ctrl_ff <= pwdata[2:0];
        end
    end

    wire isCmd = op_ff == OP_CMD;
    wire isAddr = op_ff == OP_ADDR;
    wire isRead = op_ff == OP_RDATA;
    wire active = state_ff != ST_IDLE;
    wire strobeLow = state_ff == ST_LOW;
    wire nxt_cmdLatch = active && isCmd;
    // Held while idle, dropped as any op starts; an address write raises it again one cycle later
    wire nxt_addrLatch = active ? isAddr : (pins_ff.addrLatch && !startOp);
    wire nxt_chipSel_n = !(ctrl_ff[`NFC_CTRL_CE_BIT] || active);
    wire nxt_writeStrobe_n = !(strobeLow && !isRead);
    wire nxt_read_strobe_n = !(strobeLow && isRead);
    wire nxt_writeProt_n = !ctrl_ff[`NFC_CTRL_WP_BIT];
    wire nxt_spare_access_n = !ctrl_ff[`NFC_CTRL_SE_BIT];
    // Bus released in the same cycle as the answer
    wire nxt_ioOe = active && !isRead && state_ff != ST_DONE;

    always_ff @(posedge clk) begin
        if (rst) begin
            pins_ff <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipSel_n: 1'b1, writeStrobe_n: 1'b1,
                read_strobe_n: 1'b1, writeProt_n: 1'b0, spare_access_n: 1'b1};
            ioOut_ff <= 8'h00;
            ioOe_ff <= 1'b0;
        end else begin
            pins_ff <= '{cmdLatch: nxt_cmdLatch, addrLatch: nxt_addrLatch, chipSel_n: nxt_chipSel_n,
                writeStrobe_n: nxt_writeStrobe_n, read_strobe_n: nxt_read_strobe_n,
                writeProt_n: nxt_writeProt_n, spare_access_n: nxt_spare_access_n};
            if (startOp) begin
                ioOut_ff <= pwdata[7:0];
            end
            ioOe_ff <= nxt_ioOe;
        end
    end

    // ****************************************
    // Read capture and busy tracking
    // ****************************************
    // Last cycle of the high phase: byte has passed the synchroniser
    wire capRead = state_ff == ST_HIGH && cntZero && isRead;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (capRead) begin
            rdata_ff <= ioSync_ff;
        end
    end

    // Record last command family; busy flag follows ready line
    always_ff @(posedge clk) begin
        if (rst) begin
            lastOp_ff <= 2'h0;
            busyOp_ff <= 1'b0;
        end else begin
            if (startOp && hitCmd) begin
                case (pwdata[7:0])
                    `NFC_CMD_PROGRAM: begin
                        lastOp_ff <= 2'h1;
                    end
                    `NFC_CMD_ERASE2: begin
                        lastOp_ff <= 2'h2;
                    end
                    `NFC_CMD_SUSPEND: begin
                        lastOp_ff <= 2'h3;
                    end
                    `NFC_CMD_RESET: begin
                        lastOp_ff <= 2'h0;
                    end
                    default: begin
                        lastOp_ff <= lastOp_ff;
                    end
                endcase
            end
            busyOp_ff <= !rbSync_ff;
        end
    end

    // ****************************************
    // Address byte count
    // ****************************************
    // Lets software confirm how many address bytes followed the last command
    wire cmdStart = startOp && hitCmd;
    wire addrStart = startOp && hitAddr;
    wire addrSat = addrCnt_ff == 3'h7;
    wire [2:0] nxt_addrCnt = cmdStart ? 3'h0 : ((addrStart && !addrSat) ? addrCnt_ff + 3'h1 : addrCnt_ff);

    always_ff @(posedge clk) begin
        if (rst) begin
            addrCnt_ff <= 3'h0;
        end else begin
            addrCnt_ff <= nxt_addrCnt;
        end
    end

    // ****************************************
    // Program time watchdog
    // ****************************************
    // Counts busy cycles after a program commit; sticky until a reset command
    wire progBusy = !rbSync_ff && lastOp_ff == 2'h1;
    wire limitHit = progBusy && busyCnt_ff == `NFC_BUSY_LIMIT;
    wire clrOverrun = cmdStart && pwdata[7:0] == `NFC_CMD_RESET;
    wire [15:0] nxt_busyCnt = !progBusy ? 16'h0000 : (limitHit ? busyCnt_ff : busyCnt_ff + 16'h0001);
    // Overrun set wins over a clear in the same cycle
    wire nxt_overrun = limitHit || (overrun_ff && !clrOverrun);

    always_ff @(posedge clk) begin
        if (rst) begin
            busyCnt_ff <= 16'h0000;
            overrun_ff <= 1'b0;
        end else begin
            busyCnt_ff <= nxt_busyCnt;
            overrun_ff <= nxt_overrun;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= immAck || pinAck;
            pslverr_ff <= immAck && !hitAny;
            prdata_ff <= pinAck ? {24'h0, rdata_ff} : (immAck ? immRead : 32'h0);
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;
    assign pins = pins_ff;
    assign ioOut = ioOut_ff;
    assign ioOe = ioOe_ff;
endmodule : nfc_host

// >>> verif/nfc_host_checker.sv
`timescale 1ns/100ps
module nfc_host_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire nfc_pkg::nfc_pins_type pins,
    input wire logic ioOe
);
    import nfc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence strobe_low;
        !pins.writeStrobe_n [*5];
    endsequence
    a_latch_exclusive: assert property (!(pins.cmdLatch && pins.addrLatch))
        else $error("both latches high");
    a_select_first: assert property ($fell(pins.writeStrobe_n) |-> $past(!pins.chipSel_n))
        else $error("select late");
    a_strobe_shape: assert property ($fell(pins.writeStrobe_n) |-> strobe_low ##1 pins.writeStrobe_n)
        else $error("strobe width");
    a_latch_steady: assert property (!pins.writeStrobe_n |-> $stable(pins.cmdLatch) && $stable(pins.addrLatch) && ioOe)
        else $error("latch moved");
    a_addr_held: assert property ($rose(pins.writeStrobe_n) && pins.addrLatch |-> pins.addrLatch [*5])
        else $error("address latch dropped");
    a_read_released: assert property (!pins.read_strobe_n |-> !ioOe && !pins.cmdLatch)
        else $error("bus driven in read");
    a_unmapped_error: assert property (psel && penable && !pready && paddr > 12'h014 |=> pready && pslverr)
        else $error("no error reply");
endmodule : nfc_host_checker
bind nfc_host nfc_host_checker nfc_host_checker_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .pins(pins), .ioOe(ioOe));

// >>> verif/nfc_flash_model.sv
`timescale 1ns/100ps
module nfc_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary
    parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary
    parameter logic [7:0] SPARE_FILL = 8'h3A
) (
    input wire nfc_pkg::nfc_pins_type pins,
    input wire logic [7:0] ioOut,
    input wire logic ioOe,
    output logic [7:0] ioIn,
    output logic ready_busy_n
);
    import nfc_pkg::*;
    logic [7:0] mem [16] = '{default: 8'hFF};
    logic [7:0] pend [16];
    logic [7:0] cmd = 8'hFF;
    logic [7:0] dout = 8'h00;
    logic [3:0] col = 4'h0;
    logic drv = 0;
    logic nRead = 0;
    logic half = 0;
    logic spareRd = 0;
    logic erasing = 0;
    logic suspended = 0;
    int busyLeft = 0;
    initial ready_busy_n = 1;
    // Released bus shows inverse of last byte
    assign ioIn = ioOe ? ioOut : drv ? dout : ~dout;
    always @(posedge pins.cmdLatch or posedge pins.addrLatch or posedge pins.chipSel_n or posedge ioOe) drv = 0;
    // Array operation time, frozen while an erase is suspended
    always #8 begin
        if (busyLeft > 0 && !suspended) begin
            busyLeft--;
            if (busyLeft == 0) ready_busy_n = 1;
        end
    end
    always @(posedge pins.writeStrobe_n) begin
        if (!pins.chipSel_n && pins.cmdLatch) begin
            if (pins.writeProt_n && (cmd == 8'h80 && ioIn == 8'h10 || cmd == 8'h60 && ioIn == 8'hD0)) begin
                foreach (mem[i]) mem[i] = (cmd == 8'h60) ? 8'hFF : mem[i] & pend[i];
                erasing = cmd == 8'h60;
                busyLeft = 50;
                ready_busy_n = 0;
            end else if (ioIn == 8'hB0 && erasing && !ready_busy_n) begin
                suspended = 1;
                ready_busy_n = 1;
            end else if (ioIn == 8'hD0 && suspended) begin
                suspended = 0;
                ready_busy_n = 0;
            end else if (ioIn == 8'hFF) begin
                busyLeft = 0;
                erasing = 0;
                suspended = 0;
                ready_busy_n = 1;
            end
            if (ioIn == 8'h80) pend = '{default: 8'hFF};
            half = ioIn == 8'h01;
            spareRd = ioIn == 8'h50;
            cmd = ioIn;
            nRead = 0;
        end else if (!pins.chipSel_n && pins.addrLatch) col = {ioIn[3] | half, ioIn[2:0]};
        else if (!pins.chipSel_n) begin
            pend[col] = ioIn;
            col++;
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (!pins.chipSel_n) begin
            drv = 1;
            case (cmd)
                8'h90: dout = nRead ? DEVICE_ID : MAKER_ID;
                8'h70: dout = {pins.writeProt_n, ready_busy_n, suspended, 5'h00};
                default: begin
                    // Spare bytes exist only while spare access is asserted
                    dout = spareRd ? (pins.spare_access_n ? 8'hFF : SPARE_FILL) : mem[col];
                    col++;
                end
            endcase
            nRead = 1;
        end
    end
endmodule : nfc_flash_model

// >>> verif/nfc_host_tb.sv
`timescale 1ns/100ps
`include "nfc_cfg.svh"
module nfc_host_tb;
    import nfc_pkg::*;
    localparam logic [7:0] MID = 8'h5E; // Arbitrary
    localparam logic [7:0] DID = 8'h72; // Arbitrary
    localparam logic [7:0] SPARE_FILL = 8'hC6;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ioOe, ready_busy_n, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] ioOut, ioIn;
    nfc_pins_type pins;
    int fails = 0, n_tests = 0;
    always #4 clk = ~clk;
    nfc_host nfc_host_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .ioOut(ioOut),
        .ioOe(ioOe), .ioIn(ioIn), .ready_busy_n(ready_busy_n));
    nfc_flash_model #(.MAKER_ID(MID), .DEVICE_ID(DID), .SPARE_FILL(SPARE_FILL)) nfc_flash_model_i (.pins(pins),
        .ioOut(ioOut),
        .ioOe(ioOe), .ioIn(ioIn), .ready_busy_n(ready_busy_n));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 300);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 300) begin
            fails++;
            end_sim();
        end
    endtask : apb
    task automatic op(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d});
    endtask : op
    task automatic settle_read;
        int i;
        for (i = 0; i < 100 && rd[0] !== 1'b1; i++) apb(0, `NFC_REG_STATUS, 0);
        if (i >= 100) begin
            fails++;
            end_sim();
        end
        op(`NFC_REG_CMD, 8'h00);
        op(`NFC_REG_ADDR, 8'h02);
        apb(0, `NFC_REG_RDATA, 0);
    endtask : settle_read
    task automatic t_id;
        op(`NFC_REG_CTRL, 8'h01);
        op(`NFC_REG_CMD, 8'h90);
        op(`NFC_REG_ADDR, 8'h00);
        apb(0, `NFC_REG_RDATA, 0);
        check(rd[7:0], MID);
        apb(0, `NFC_REG_RDATA, 0);
        check(rd[7:0], DID);
        op(`NFC_REG_CMD, 8'h70);
        apb(0, `NFC_REG_RDATA, 0);
        check(rd[7:0], 8'hC0);
        $display("test id and status done");
    endtask : t_id
    task automatic t_program;
        op(`NFC_REG_CTRL, 8'h03);
        for (int k = 0; k < 2; k++) begin
            op(`NFC_REG_CMD, 8'h80);
            op(`NFC_REG_ADDR, 8'h02);
            op(`NFC_REG_WDATA, 8'h5A);
            op(`NFC_REG_CMD, 8'h10);
            apb(0, `NFC_REG_STATUS, 0);
            check(rd[1], k[0]);
            check({rd[8], rd[4:3]}, 3'h1);
            settle_read();
            check(rd[7:0], k ? 8'h5A : 8'hFF);
            op(`NFC_REG_CTRL, 8'h01);
        end
        op(`NFC_REG_CMD, 8'h01);
        op(`NFC_REG_ADDR, 8'h02);
        apb(0, `NFC_REG_RDATA, 0);
        check(rd[7:0], 8'hFF);
        op(`NFC_REG_CMD, 8'h60);
        op(`NFC_REG_ADDR, 8'h00);
        op(`NFC_REG_ADDR, 8'h00);
        apb(0, `NFC_REG_STATUS, 0);
        check(rd[7:5], 3'h2);
        op(`NFC_REG_CMD, 8'hD0);
        op(`NFC_REG_CMD, 8'hB0);
        apb(0, `NFC_REG_STATUS, 0);
        check({rd[4:3], rd[1:0]}, 4'hD);
        op(`NFC_REG_CMD, 8'hD0);
        apb(0, `NFC_REG_STATUS, 0);
        check({rd[4:3], rd[1:0]}, 4'hA);
        settle_read();
        check(rd[7:0], 8'hFF);
        op(`NFC_REG_CMD, 8'hFF);
        apb(0, `NFC_REG_STATUS, 0);
        check(rd[4:3], 2'h0);
        apb(0, 12'h020, 0);
        check(err, 1);
        check(rd, 0);
        $display("test program erase done");
    endtask : t_program
    task automatic t_spare;
        for (int k = 0; k < 2; k++) begin
            op(`NFC_REG_CTRL, k ? 8'h05 : 8'h01);
            op(`NFC_REG_CMD, 8'h50);
            op(`NFC_REG_ADDR, 8'h03);
            apb(0, `NFC_REG_RDATA, 0);
            check(rd[7:0], k ? SPARE_FILL : 8'hFF);
        end
        $display("test spare access done");
    endtask : t_spare
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_id();
        t_program();
        t_spare();
        end_sim();
    end
endmodule : nfc_host_tb
